// *** bench/mgp_partner.sv ***
/*
 * Management controller and boundary-scan tester model.
 * Assumes the bench calls one task at a time; MDIO has a pull-up.
 */
`timescale 1ns/1ns
module mgp_partner (
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  localparam int HALF = 62;
  logic m_oe = 1'b0;
  logic m_out = 1'b1;

  // pulled-up line, high when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);

  // both clocks stand low while idle
  initial begin
    mdc = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic edge_mdc();
    #(HALF) mdc = 1'b1;
    #(HALF + 1) mdc = 1'b0;
  endtask

  // preamble, header, turnaround, data; line freed for reads
  task automatic frame(input logic [13:0] hdr, input logic [15:0] wd,
                       input logic is_rd, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {hdr, 2'h2, wd};
    rd = 16'h0;
    m_oe = 1'b1;
    m_out = 1'b1;
    repeat (8) edge_mdc();
    for (int i = 31; i >= 0; i--) begin
      m_oe = !(is_rd && i < 18);
      m_out = bits[i];
      #(HALF) rd = {rd[14:0], mdio_in};
      mdc = 1'b1;
      #(HALF + 1) mdc = 1'b0;
    end
    m_oe = 1'b0;
    repeat (2) edge_mdc();
  endtask

  // TMS and TDI change with TCK low, TCK back low afterwards
  task automatic tap(input logic t_ms, input logic t_di, output logic o,
                     output logic oe);
    tms = t_ms;
    tdi = t_di;
    #(HALF) o = tdo_out;
    oe = tdo_oe;
    tck = 1'b1;
    #(HALF + 1) tck = 1'b0;
  endtask
endmodule // mgp_partner

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for the management and test port pin logic.
 * Assumes mgp_pkg, mgp_top and mgp_partner are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic device_reset_n = 1'b0;
  logic soft_reset = 1'b0;
  logic pin_power_down_low = 1'b1;
  logic reg_power_down = 1'b0;
  logic clause_select = 1'b1;
  logic [4:0] port_address_straps = 5'h15;
  logic [15:0] mgmt_rd_data = 16'hc3a5;
  logic mdc, mdio_in, mdio_out, mdio_oe, tck, tms, tdi, tdo_out, tdo_oe;
  logic mgmt_rd, mgmt_wr, spare_strap_level, status_valid;
  logic oe_seen, toe_seen;
  logic [4:0] mgmt_dev, cap_dev;
  logic [15:0] mgmt_addr, mgmt_wdata, cap_addr, cap_wdata, rd;
  logic [3:0] jtag_instr;
  int rd_cnt, wr_cnt, cyc, error_cnt, checks;

  mgp_top uut (
    .clock, .sys_rst, .device_reset_n, .soft_reset, .pin_power_down_low,
    .reg_power_down, .clause_select, .port_address_straps, .mdc, .mdio_in,
    .mdio_out, .mdio_oe, .tck, .tms, .tdi, .tdo_out, .tdo_oe, .mgmt_rd_data,
    .mgmt_rd, .mgmt_wr, .mgmt_dev, .mgmt_addr, .mgmt_wdata,
    .spare_strap_level, .status_valid, .jtag_instr
  );
  mgp_partner peer (
    .mdc, .mdio_in, .mdio_out, .mdio_oe, .tck, .tms, .tdi, .tdo_out, .tdo_oe
  );

  always #5 clock = ~clock;

  // ****************************************
  // Monitors and helpers
  // ****************************************
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (mdio_oe === 1'b1) oe_seen <= 1'b1;
    if (tdo_oe === 1'b1) toe_seen <= 1'b1;
    if (mgmt_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      cap_addr <= mgmt_addr;
    end
    if (mgmt_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      cap_addr <= mgmt_addr;
      cap_dev <= mgmt_dev;
      cap_wdata <= mgmt_wdata;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic mf(input logic [1:0] st, input logic [1:0] op,
                    input logic [4:0] pa, input logic [4:0] da,
                    input logic [15:0] wd);
    oe_seen = 1'b0;
    toe_seen = 1'b0;
    rd_cnt = 0;
    wr_cnt = 0;
    peer.frame({st, op, pa, da}, wd, op[1], rd);
    tick(8);
  endtask

  task automatic pulse_soft();
    tick(3);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(3);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_float();
    logic o, oe;
    tick(3);
    sys_rst = 1'b0;
    tick(5);
    mf(2'h1, 2'h2, 5'h14, 5'h07, 16'h0);
    cmp(oe_seen, 1'b0, "mdio driven in reset");
    cmp(rd_cnt, 0, "read taken in reset");
    for (int i = 0; i < 6; i++) peer.tap(i > 0 && i < 3, 1'b1, o, oe);
    cmp(toe_seen, 1'b0, "tdo driven in reset");
    while (cyc < mgp_pkg::RST_HOLD_CYC) @(posedge clock);
    #1 device_reset_n = 1'b1;
    tick(10);
  endtask

  task automatic t_c22();
    mf(2'h1, 2'h2, 5'h14, 5'h07, 16'h0);
    cmp(rd, 16'hc3a5, "c22 read data");
    cmp(rd_cnt, 1, "c22 read count");
    cmp(cap_addr, 16'h0007, "c22 read addr");
    cmp(mdio_oe, 1'b0, "mdio kept after read");
    mf(2'h1, 2'h1, 5'h14, 5'h1f, 16'h5a0f);
    cmp(wr_cnt, 1, "c22 write count");
    cmp(cap_wdata, 16'h5a0f, "c22 write data");
    cmp(cap_addr, 16'h001f, "c22 write addr");
    cmp(oe_seen, 1'b0, "mdio driven in write");
    cmp(spare_strap_level, 1'b1, "spare strap");
    port_address_straps = 5'h14;
    tick(4);
    cmp(spare_strap_level, 1'b0, "spare strap low");
    port_address_straps = 5'h15;
    tick(4);
    cmp(status_valid, 1'b1, "status valid");
  endtask

  task automatic t_refuse();
    logic [6:0] cs [4] = '{7'h35, 7'h24, 7'h3c, 7'h14};
    for (int i = 0; i < 4; i++) begin
      mf(cs[i][6:5], 2'h2, cs[i][4:0], 5'h07, 16'h0);
      cmp(oe_seen, 1'b0, "answered foreign frame");
      cmp(rd_cnt, 0, "read of foreign frame");
    end
    mf(2'h1, 2'h1, 5'h15, 5'h07, 16'h1111);
    cmp(wr_cnt, 0, "write of foreign frame");
  endtask

  task automatic t_clause();
    clause_select = 1'b0;
    tick(5);
    mf(2'h1, 2'h2, 5'h14, 5'h02, 16'h0);
    cmp(rd_cnt, 1, "clause changed without reset");
    pulse_soft();
    mf(2'h1, 2'h2, 5'h14, 5'h02, 16'h0);
    cmp(oe_seen, 1'b0, "c22 after switch");
    mf(2'h0, 2'h0, 5'h14, 5'h03, 16'h1234);
    mf(2'h0, 2'h1, 5'h14, 5'h03, 16'hbeef);
    cmp(cap_wdata, 16'hbeef, "c45 write data");
    cmp(cap_addr, 16'h1234, "c45 write addr");
    cmp(cap_dev, 5'h03, "c45 write dev");
    mgmt_rd_data = 16'h0ff1;
    mf(2'h0, 2'h2, 5'h14, 5'h03, 16'h0);
    cmp(rd, 16'h0ff1, "c45 read data");
    mf(2'h0, 2'h3, 5'h14, 5'h03, 16'h0);
    cmp(cap_addr, 16'h1235, "c45 post increment");
    clause_select = 1'b1;
    pulse_soft();
  endtask

  task automatic t_power();
    reg_power_down = 1'b1;
    tick(3);
    cmp(status_valid, 1'b0, "status in reg power down");
    mgmt_rd_data = 16'h9e61;
    mf(2'h1, 2'h2, 5'h14, 5'h05, 16'h0);
    cmp(rd, 16'h9e61, "read in reg power down");
    mf(2'h1, 2'h1, 5'h14, 5'h05, 16'h7777);
    cmp(cap_wdata, 16'h7777, "write in reg power down");
    reg_power_down = 1'b0;
    pin_power_down_low = 1'b0;
    tick(5);
    cmp(status_valid, 1'b0, "status in pin power down");
    mf(2'h1, 2'h2, 5'h14, 5'h05, 16'h0);
    cmp(oe_seen, 1'b0, "mdio driven in pin power down");
    pin_power_down_low = 1'b1;
    tick(5);
    cmp(status_valid, 1'b1, "status after power up");
  endtask

  task automatic t_tap();
    logic o, oe, prev;
    logic [3:0] ir_in = 4'ha;
    logic [3:0] dr_in = 4'hd;
    for (int i = 0; i < 5; i++) peer.tap(i > 0 && i < 3, 1'b1, o, oe);
    for (int i = 0; i < 4; i++) begin
      peer.tap(i == 3, ir_in[i], o, oe);
      cmp(oe, 1'b1, "tdo enable in ir shift");
      cmp(o, mgp_pkg::IR_CAPTURE[i], "ir capture out");
    end
    peer.tap(1'b1, 1'b1, o, oe);
    cmp(oe, 1'b0, "tdo enable after shift");
    peer.tap(1'b0, 1'b1, o, oe);
    tick(5);
    cmp(jtag_instr, ir_in, "instruction loaded");
    for (int i = 0; i < 3; i++) peer.tap(i == 0, 1'b1, o, oe);
    prev = 1'b0;
    for (int i = 0; i < 4; i++) begin
      peer.tap(i == 3, dr_in[i], o, oe);
      cmp(o, prev, "bypass out");
      prev = dr_in[i];
    end
    peer.tap(1'b1, 1'b1, o, oe);
    peer.tap(1'b0, 1'b1, o, oe);
    tick(5);
    cmp(tdo_oe, 1'b0, "tdo driven in idle");
    for (int i = 0; i < 5; i++) peer.tap(1'b1, 1'b1, o, oe);
    tick(5);
    cmp(jtag_instr, mgp_pkg::IR_RESET, "instruction after reset");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    t_reset_float();
    t_c22();
    t_refuse();
    t_clause();
    t_power();
    t_tap();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_top

// *** hw/mgp_pkg.sv ***
/*
 * Shared constants and state types of the management and test port pins.
 * Assumes a 100 MHz system clock and pins synchronised before use.
 */
package mgp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int RST_HOLD_US = 10;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;

  // ****************************************
  // Management frame layout
  // ****************************************
  localparam int HDR_BITS = 14;
  localparam int DATA_BITS = 16;
  localparam int HDR_ST_MSB = 13;
  localparam int HDR_OP_MSB = 11;
  localparam int HDR_PA_MSB = 9;
  localparam int HDR_DA_MSB = 4;
  localparam logic [1:0] ST_C22 = 2'h1;
  localparam logic [1:0] ST_C45 = 2'h0;
  localparam logic [1:0] OP22_WR = 2'h1;
  localparam logic [1:0] OP22_RD = 2'h2;
  localparam logic [1:0] OP45_ADR = 2'h0;
  localparam logic [1:0] OP45_WR = 2'h1;
  localparam logic [1:0] OP45_RDI = 2'h2;
  localparam logic [1:0] OP45_RD = 2'h3;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [4:0] HDR_LAST = 5'h0d;

  // ****************************************
  // Test port
  // ****************************************
  localparam int IR_BITS = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = 4'hf;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_HDR = 3'h1,
    M_TA1 = 3'h2,
    M_TA2 = 3'h3,
    M_RDAT = 3'h4,
    M_WDAT = 3'h5
  } mgp_mstate_t;

  typedef enum logic [3:0] {
    T_TLR = 4'hf, T_RTI = 4'hc, T_SEL_DR = 4'h7, T_CAP_DR = 4'h6,
    T_SH_DR = 4'h2, T_EX1_DR = 4'h1, T_PA_DR = 4'h3, T_EX2_DR = 4'h0,
    T_UPD_DR = 4'h5, T_SEL_IR = 4'h4, T_CAP_IR = 4'he, T_SH_IR = 4'ha,
    T_EX1_IR = 4'h9, T_PA_IR = 4'hb, T_EX2_IR = 4'h8, T_UPD_IR = 4'hd
  } mgp_tap_t;

endpackage

// *** hw/mgp_sync2.sv ***
/*
 * Two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is a slow level or a clock far below the system clock.
 */
`timescale 1ns/1ns
module mgp_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule // mgp_sync2

// *** hw/mgp_top.sv ***
/*
 * Management serial port and boundary-scan port pin logic.
 * Assumes MDC and TCK run far below the 100 MHz clock; read data on
 * mgmt_rd_data is valid two MDC periods after mgmt_rd pulses.
 */
// Summary of operation
// - Lowest address strap never matched; exported as a general input level.
// - MDC is the only management clock; all MDIO timing follows its edges.
// - While device reset is low, MDIO and TDO float.
// - Register power down keeps management reads and writes working.
// - Status is marked unreliable while either power down is active.
// - Pin power down floats MDIO; register power down keeps driving it.
// - TDI shifts instructions and data in while the test port runs.
// - TDO shifts out in shift states, otherwise high impedance.
// - TMS steers the test access port controller state.
// - TCK clocks controller state and test data; tied low when unused.
// - Answer only when frame address bits 4:1 equal straps and bit 0 is 0.
// - Clause select high picks 22, low picks 45; taken only at reset.
`timescale 1ns/1ns
module mgp_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic device_reset_n,
  input wire logic soft_reset,
  input wire logic pin_power_down_low,
  input wire logic reg_power_down,
  input wire logic clause_select,
  input wire logic [4:0] port_address_straps,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [15:0] mgmt_rd_data,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [4:0] mgmt_dev,
  output logic [15:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  output logic spare_strap_level,
  output logic status_valid,
  output logic [3:0] jtag_instr
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [12:0] pins_s;
  logic mdc_s, mdio_s, tck_s, tms_s, tdi_s, rstn_s, pdn_s, clause_s;
  logic spare_s;
  logic [3:0] straps_s;

  mgp_sync2 #(.W(13)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({mdc, mdio_in, tck, tms, tdi, device_reset_n, pin_power_down_low,
        clause_select, port_address_straps}),
    .q(pins_s)
  );

  assign {mdc_s, mdio_s, tck_s, tms_s, tdi_s, rstn_s, pdn_s, clause_s,
          straps_s, spare_s} = pins_s;

  logic dev_rst, pd_pin;
  assign dev_rst = ~rstn_s;
  assign pd_pin = ~pdn_s;

  // ****************************************
  // Edges, straps and clause latch
  // ****************************************
  logic mdc_d_ff, tck_d_ff, c22_ff, spare_ff, stat_ok_ff;
  logic nxt_c22, nxt_stat_ok;
  logic mdc_rise, tck_rise, tck_fall;

  assign mdc_rise = mdc_s & ~mdc_d_ff;
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;

  always_comb begin
    nxt_c22 = (dev_rst | soft_reset) ? clause_s : c22_ff;
    nxt_stat_ok = ~(pd_pin | reg_power_down);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_d_ff <= 1'b0;
      tck_d_ff <= 1'b0;
      c22_ff <= 1'b0;
      spare_ff <= 1'b0;
      stat_ok_ff <= 1'b0;
    end else begin
      mdc_d_ff <= mdc_s;
      tck_d_ff <= tck_s;
      c22_ff <= nxt_c22;
      spare_ff <= spare_s;
      stat_ok_ff <= nxt_stat_ok;
    end
  end

  // ****************************************
  // Frame decoding
  // ****************************************
  function automatic logic addr_match(input logic [13:0] h,
                                      input logic [3:0] st);
    addr_match = (h[mgp_pkg::HDR_PA_MSB -: 4] == st) &&
                 !h[mgp_pkg::HDR_PA_MSB-4];
  endfunction

  function automatic logic st_ok(input logic [13:0] h, input logic c22);
    st_ok = h[mgp_pkg::HDR_ST_MSB -: 2] ==
            (c22 ? mgp_pkg::ST_C22 : mgp_pkg::ST_C45);
  endfunction

  function automatic logic is_rd(input logic [1:0] op, input logic c22);
    is_rd = c22 ? (op == mgp_pkg::OP22_RD) :
                  (op == mgp_pkg::OP45_RD || op == mgp_pkg::OP45_RDI);
  endfunction

  // ****************************************
  // Management frame engine
  // ****************************************
  mgp_pkg::mgp_mstate_t mst_ff, nxt_mst;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [13:0] hdr_ff, nxt_hdr, hdr_in;
  logic [15:0] sh_ff, nxt_sh;
  logic [15:0] c45a_ff, nxt_c45a;
  logic pre_ff, nxt_pre, act_ff, nxt_act, rd_ff, nxt_rd;
  logic drv_ff, nxt_drv, mout_ff, nxt_mout, moe_ff, nxt_moe;
  logic mrd_ff, nxt_mrd, mwr_ff, nxt_mwr;
  logic [4:0] mdev_ff, nxt_mdev;
  logic [15:0] maddr_ff, nxt_maddr, mwd_ff, nxt_mwd;
  logic [1:0] op_q;

  assign hdr_in = {hdr_ff[12:0], mdio_s};
  assign op_q = hdr_ff[mgp_pkg::HDR_OP_MSB -: 2];

  always_comb begin
    nxt_mst = mst_ff;
    nxt_cnt = cnt_ff;
    nxt_hdr = hdr_ff;
    nxt_sh = sh_ff;
    nxt_c45a = c45a_ff;
    nxt_pre = pre_ff;
    nxt_act = act_ff;
    nxt_rd = rd_ff;
    nxt_drv = drv_ff;
    nxt_mout = mout_ff;
    nxt_mrd = 1'b0;
    nxt_mwr = 1'b0;
    nxt_mdev = mdev_ff;
    nxt_maddr = maddr_ff;
    nxt_mwd = mwd_ff;
    if (mdc_rise) begin
      case (mst_ff)
        mgp_pkg::M_IDLE: begin
          if (mdio_s) begin
            nxt_pre = 1'b1;
          end else if (pre_ff) begin
            nxt_mst = mgp_pkg::M_HDR;
            nxt_hdr = 14'h0000;
            nxt_cnt = 5'h01;
          end
        end
        mgp_pkg::M_HDR: begin
          nxt_hdr = hdr_in;
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == mgp_pkg::HDR_LAST) begin
            nxt_act = addr_match(hdr_in, straps_s) && st_ok(hdr_in, c22_ff);
            nxt_rd = is_rd(hdr_in[mgp_pkg::HDR_OP_MSB -: 2], c22_ff);
            nxt_mst = mgp_pkg::M_TA1;
            nxt_mdev = hdr_in[mgp_pkg::HDR_DA_MSB:0];
            nxt_maddr = c22_ff ? {11'h000, hdr_in[mgp_pkg::HDR_DA_MSB:0]} :
                        c45a_ff;
            nxt_mrd = nxt_act & nxt_rd;
          end
        end
        mgp_pkg::M_TA1: begin
          // drive zero in second turnaround slot
          nxt_drv = act_ff & rd_ff;
          nxt_mout = 1'b0;
          nxt_mst = mgp_pkg::M_TA2;
        end
        mgp_pkg::M_TA2: begin
          nxt_cnt = 5'h00;
          if (rd_ff) begin
            nxt_mout = mgmt_rd_data[15];
            nxt_sh = {mgmt_rd_data[14:0], 1'b0};
            nxt_mst = mgp_pkg::M_RDAT;
          end else begin
            nxt_mst = mgp_pkg::M_WDAT;
          end
        end
        mgp_pkg::M_RDAT: begin
          if (cnt_ff == mgp_pkg::LAST_BIT) begin
            nxt_drv = 1'b0;
            nxt_pre = 1'b0;
            nxt_mst = mgp_pkg::M_IDLE;
            if (act_ff && !c22_ff && op_q == mgp_pkg::OP45_RDI) begin
              nxt_c45a = c45a_ff + 16'h0001;
            end
          end else begin
            nxt_mout = sh_ff[15];
            nxt_sh = {sh_ff[14:0], 1'b0};
            nxt_cnt = cnt_ff + 5'h01;
          end
        end
        mgp_pkg::M_WDAT: begin
          nxt_sh = {sh_ff[14:0], mdio_s};
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == mgp_pkg::LAST_BIT) begin
            nxt_pre = 1'b0;
            nxt_mst = mgp_pkg::M_IDLE;
            if (act_ff && !c22_ff && op_q == mgp_pkg::OP45_ADR) begin
              nxt_c45a = nxt_sh;
            end else if (act_ff) begin
              nxt_mwr = 1'b1;
              nxt_mwd = nxt_sh;
            end
          end
        end
        default: begin
          nxt_mst = mgp_pkg::M_IDLE;
        end
      endcase
    end
    if (dev_rst) begin
      nxt_mst = mgp_pkg::M_IDLE;
      nxt_pre = 1'b0;
      nxt_drv = 1'b0;
    end
    // pin power down floats, register power down does not
    nxt_moe = nxt_drv & ~dev_rst & ~pd_pin;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mst_ff <= mgp_pkg::M_IDLE;
      cnt_ff <= 5'h00;
      hdr_ff <= 14'h0000;
      sh_ff <= 16'h0000;
      c45a_ff <= 16'h0000;
      pre_ff <= 1'b0;
      act_ff <= 1'b0;
      rd_ff <= 1'b0;
      drv_ff <= 1'b0;
      mout_ff <= 1'b0;
      moe_ff <= 1'b0;
      mrd_ff <= 1'b0;
      mwr_ff <= 1'b0;
      mdev_ff <= 5'h00;
      maddr_ff <= 16'h0000;
      mwd_ff <= 16'h0000;
    end else begin
      mst_ff <= nxt_mst;
      cnt_ff <= nxt_cnt;
      hdr_ff <= nxt_hdr;
      sh_ff <= nxt_sh;
      c45a_ff <= nxt_c45a;
      pre_ff <= nxt_pre;
      act_ff <= nxt_act;
      rd_ff <= nxt_rd;
      drv_ff <= nxt_drv;
      mout_ff <= nxt_mout;
      moe_ff <= nxt_moe;
      mrd_ff <= nxt_mrd;
      mwr_ff <= nxt_mwr;
      mdev_ff <= nxt_mdev;
      maddr_ff <= nxt_maddr;
      mwd_ff <= nxt_mwd;
    end
  end

  // ****************************************
  // Test access port
  // ****************************************
  function automatic mgp_pkg::mgp_tap_t tap_next(input mgp_pkg::mgp_tap_t s,
                                                 input logic m);
    case (s)
      mgp_pkg::T_TLR: tap_next = m ? mgp_pkg::T_TLR : mgp_pkg::T_RTI;
      mgp_pkg::T_RTI: tap_next = m ? mgp_pkg::T_SEL_DR : mgp_pkg::T_RTI;
      mgp_pkg::T_SEL_DR: tap_next = m ? mgp_pkg::T_SEL_IR : mgp_pkg::T_CAP_DR;
      mgp_pkg::T_CAP_DR: tap_next = m ? mgp_pkg::T_EX1_DR : mgp_pkg::T_SH_DR;
      mgp_pkg::T_SH_DR: tap_next = m ? mgp_pkg::T_EX1_DR : mgp_pkg::T_SH_DR;
      mgp_pkg::T_EX1_DR: tap_next = m ? mgp_pkg::T_UPD_DR : mgp_pkg::T_PA_DR;
      mgp_pkg::T_PA_DR: tap_next = m ? mgp_pkg::T_EX2_DR : mgp_pkg::T_PA_DR;
      mgp_pkg::T_EX2_DR: tap_next = m ? mgp_pkg::T_UPD_DR : mgp_pkg::T_SH_DR;
      mgp_pkg::T_UPD_DR: tap_next = m ? mgp_pkg::T_SEL_DR : mgp_pkg::T_RTI;
      mgp_pkg::T_SEL_IR: tap_next = m ? mgp_pkg::T_TLR : mgp_pkg::T_CAP_IR;
      mgp_pkg::T_CAP_IR: tap_next = m ? mgp_pkg::T_EX1_IR : mgp_pkg::T_SH_IR;
      mgp_pkg::T_SH_IR: tap_next = m ? mgp_pkg::T_EX1_IR : mgp_pkg::T_SH_IR;
      mgp_pkg::T_EX1_IR: tap_next = m ? mgp_pkg::T_UPD_IR : mgp_pkg::T_PA_IR;
      mgp_pkg::T_PA_IR: tap_next = m ? mgp_pkg::T_EX2_IR : mgp_pkg::T_PA_IR;
      mgp_pkg::T_EX2_IR: tap_next = m ? mgp_pkg::T_UPD_IR : mgp_pkg::T_SH_IR;
      mgp_pkg::T_UPD_IR: tap_next = m ? mgp_pkg::T_SEL_DR : mgp_pkg::T_RTI;
      default: tap_next = mgp_pkg::T_TLR;
    endcase
  endfunction

  mgp_pkg::mgp_tap_t tap_ff, nxt_tap;
  logic [3:0] irs_ff, nxt_irs, ir_ff, nxt_ir;
  logic byp_ff, nxt_byp, tout_ff, nxt_tout, toe_ff, nxt_toe;
  logic shifting;

  assign shifting = (tap_ff == mgp_pkg::T_SH_DR) ||
                    (tap_ff == mgp_pkg::T_SH_IR);

  always_comb begin
    nxt_tap = tap_ff;
    nxt_irs = irs_ff;
    nxt_ir = ir_ff;
    nxt_byp = byp_ff;
    nxt_tout = tout_ff;
    // TCK rise moves state and data
    if (tck_rise) begin
      nxt_tap = tap_next(tap_ff, tms_s);
      case (tap_ff)
        mgp_pkg::T_TLR: nxt_ir = mgp_pkg::IR_RESET;
        mgp_pkg::T_CAP_IR: nxt_irs = mgp_pkg::IR_CAPTURE;
        mgp_pkg::T_SH_IR: nxt_irs = {tdi_s, irs_ff[3:1]};
        mgp_pkg::T_UPD_IR: nxt_ir = irs_ff;
        mgp_pkg::T_CAP_DR: nxt_byp = 1'b0;
        mgp_pkg::T_SH_DR: nxt_byp = tdi_s;
        default: nxt_byp = byp_ff;
      endcase
    end
    if (tck_fall) begin
      nxt_tout = (tap_ff == mgp_pkg::T_SH_IR) ? irs_ff[0] : byp_ff;
    end
    if (dev_rst) begin
      nxt_tap = mgp_pkg::T_TLR;
      nxt_ir = mgp_pkg::IR_RESET;
    end
    nxt_toe = shifting & ~dev_rst;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tap_ff <= mgp_pkg::T_TLR;
      irs_ff <= 4'h0;
      ir_ff <= mgp_pkg::IR_RESET;
      byp_ff <= 1'b0;
      tout_ff <= 1'b0;
      toe_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      irs_ff <= nxt_irs;
      ir_ff <= nxt_ir;
      byp_ff <= nxt_byp;
      tout_ff <= nxt_tout;
      toe_ff <= nxt_toe;
    end
  end

  assign mdio_out = mout_ff;
  assign mdio_oe = moe_ff;
  assign tdo_out = tout_ff;
  assign tdo_oe = toe_ff;
  assign mgmt_rd = mrd_ff;
  assign mgmt_wr = mwr_ff;
  assign mgmt_dev = mdev_ff;
  assign mgmt_addr = maddr_ff;
  assign mgmt_wdata = mwd_ff;
  assign spare_strap_level = spare_ff;
  assign status_valid = stat_ok_ff;
  assign jtag_instr = ir_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_rd_ta;
    mst_ff == mgp_pkg::M_TA1 && mdc_rise && act_ff && rd_ff &&
      !dev_rst && !pd_pin;
  endsequence

  sequence s_drive_zero;
    moe_ff && !mout_ff;
  endsequence

  a_mdio_rst_float: assert property (dev_rst |=> !moe_ff)
    else $error("MDIO driven during device reset");
  a_tdo_rst_float: assert property (dev_rst |=> !toe_ff)
    else $error("TDO driven during device reset");
  a_mdio_pin_pd: assert property (pd_pin |=> !moe_ff)
    else $error("MDIO driven in pin power down");
  a_mdio_reg_pd: assert property (reg_power_down &&
      !pd_pin && !dev_rst && mst_ff == mgp_pkg::M_RDAT &&
      cnt_ff != mgp_pkg::LAST_BIT && mdc_rise && drv_ff |=> moe_ff)
    else $error("MDIO released in register power down");
  a_status_flag: assert property ((pd_pin || reg_power_down) |=>
      !stat_ok_ff)
    else $error("Status marked valid in power down");
  a_mdio_on_mdc: assert property ($changed(mout_ff) |->
      $past(mdc_rise))
    else $error("MDIO data changed off an MDC edge");
  a_read_ta: assert property (s_rd_ta |=> s_drive_zero)
    else $error("Turnaround zero not driven");
  a_addr_match: assert property (mst_ff == mgp_pkg::M_HDR &&
      cnt_ff == mgp_pkg::HDR_LAST && mdc_rise &&
      hdr_in[mgp_pkg::HDR_PA_MSB-4] |=> !act_ff)
    else $error("Frame with odd address answered");
  a_spare_level: assert property (##1 spare_ff == $past(spare_s))
    else $error("Spare strap level not followed");
  a_clause_hold: assert property (!dev_rst && !soft_reset |=>
      $stable(c22_ff))
    else $error("Clause select changed outside reset");
  a_tdo_idle_hiz: assert property (!shifting |=> !toe_ff)
    else $error("TDO driven outside shift state");
  a_tap_reset: assert property (tck_rise && tms_s && !dev_rst &&
      tap_ff == mgp_pkg::T_SEL_IR |=> tap_ff == mgp_pkg::T_TLR)
    else $error("TMS high did not reach reset state");
  a_tdi_shift: assert property (tck_rise && !dev_rst &&
      tap_ff == mgp_pkg::T_SH_DR |=> byp_ff == $past(tdi_s))
    else $error("TDI not shifted in");
  a_tdo_on_fall: assert property ($changed(tout_ff) |->
      $past(tck_fall))
    else $error("TDO changed off a TCK fall");

endmodule // mgp_top
